// >>> design/high_water_tracker.sv
`timescale 1ns/100ps
`default_nettype none
module high_water_tracker
    import rx_chain_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic mark_write,
    input wire logic [7:0] mark_channel,
    input wire logic [9:0] mark_data,
    output logic [9:0] mark_value,
    input wire logic block_done,
    input wire logic frame_end,
    input wire logic [7:0] engine_channel,
    output logic dma_request,
    output logic [7:0] dma_channel
);
    logic [9:0] mark_ram [CHANNELS];
    logic [9:0] fill_count [CHANNELS];
    logic [9:0] next_fill;

    assign mark_value = mark_ram[mark_channel];
    assign next_fill = fill_count[engine_channel] + 10'h001;

    always_ff @(posedge clock) begin
        if (mark_write) begin
            mark_ram[mark_channel] <= mark_data;
        end
    end

    // Mark of zero is illegal; it degrades to a request per block
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < CHANNELS; i++) begin
                fill_count[i] <= '0;
            end
            dma_request <= 1'b0;
            dma_channel <= '0;
        end else begin
            dma_request <= 1'b0;
            if (frame_end) begin
                fill_count[engine_channel] <= '0;
                dma_request <= 1'b1;
                dma_channel <= engine_channel;
            end else if (block_done) begin
                if (next_fill >= mark_ram[engine_channel]) begin
                    fill_count[engine_channel] <= '0;
                    dma_request <= 1'b1;
                    dma_channel <= engine_channel;
                end else begin
                    fill_count[engine_channel] <= next_fill;
                end
            end
        end
    end

    property p_eof_request;
        @(posedge clock) disable iff (srst)
        frame_end |=> dma_request && dma_channel == $past(engine_channel);
    endproperty
    a_eof_request: assert property (p_eof_request)
        else $error("end of frame did not request transfer");

    property p_mark_request;
        @(posedge clock) disable iff (srst)
        (block_done && !frame_end
            && next_fill >= mark_ram[engine_channel]) |=> dma_request;
    endproperty
    a_mark_request: assert property (p_mark_request)
        else $error("high water reached without request");

    property p_quiet;
        @(posedge clock) disable iff (srst)
        (!block_done && !frame_end) |=> !dma_request;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("request without engine event");

    c_mark_request: cover property (@(posedge clock) disable iff (srst)
        block_done && !frame_end ##1 dma_request);
endmodule
`default_nettype wire

// >>> design/indirect_access_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module indirect_access_ctrl
    import rx_chain_pkg::*;
#(
    parameter int ID_WIDTH = 8
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic select_write,
    input wire logic [15:0] write_data,
    output logic [ID_WIDTH-1:0] select_id,
    output logic indirect_direction,
    output logic indirect_busy,
    output logic access_read,
    output logic access_write
);
    indirect_state_type state;

    assign indirect_busy = (state == ACCESS);
    assign access_read = (state == ACCESS) && indirect_direction;
    assign access_write = (state == ACCESS) && !indirect_direction;

    // Commands while busy are dropped so the live access keeps its id
    always_ff @(posedge clock) begin
        if (srst) begin
            select_id <= '0;
            indirect_direction <= 1'b0;
        end else if (select_write && !indirect_busy) begin
            select_id <= write_data[ID_WIDTH-1:0];
            indirect_direction <= write_data[DIRECTION_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state <= IDLE;
        end else begin
            case (state)
                IDLE: begin
                    if (select_write) begin
                        state <= ACCESS;
                    end
                end
                ACCESS: state <= IDLE;
                default: state <= IDLE;
            endcase
        end
    end

    property p_busy_span;
        @(posedge clock) disable iff (srst)
        (select_write && !indirect_busy) |=> indirect_busy ##1 !indirect_busy;
    endproperty
    a_busy_span: assert property (p_busy_span)
        else $error("busy did not span exactly one access");
endmodule
`default_nettype wire

// >>> design/rx_chain_pkg.sv
// Functional notes
// - Channel code plus one gives channel number.
// - Command one reads current pointer into data.
// - Command zero writes data into start RAM.
// - Busy high throughout access, clear when done.
// - Start value is ten bits, any block.
// - Read returns live write pointer, not start.
// - Block select is ten bits across bytes.
// - Command one reads next pointer RAM entry.
// - Command zero writes next pointer RAM entry.
// - Command one reads high water RAM entry.
// - Command zero writes high water RAM entry.
// - Request DMA after high water blocks written.
// - Transmit start select register at 0980h.
// - Select registers reset to all zeros.
// - End of frame requests DMA early.
package rx_chain_pkg;
    // ********************************
    // Register map
    // ********************************
    localparam logic [11:0] RX_START_SELECT_ADDR = 12'h0900;
    localparam logic [11:0] RX_START_DATA_ADDR = 12'h0904;
    localparam logic [11:0] RX_NEXT_SELECT_ADDR = 12'h0910;
    localparam logic [11:0] RX_NEXT_DATA_ADDR = 12'h0914;
    localparam logic [11:0] RX_HWM_SELECT_ADDR = 12'h0920;
    localparam logic [11:0] RX_HWM_DATA_ADDR = 12'h0924;
    localparam logic [11:0] TX_START_SELECT_ADDR = 12'h0980;
    // ********************************
    // Field layout and sizes
    // ********************************
    localparam int CHANNEL_WIDTH = 8;
    localparam int BLOCK_WIDTH = 10;
    localparam int CHANNELS = 256;
    localparam int BLOCKS = 1024;
    localparam int DIRECTION_BIT = 14;
    localparam int BUSY_BIT = 15;
    localparam int REG_WIDTH = 16;
    localparam logic [15:0] SELECT_RESET = 16'h0000;
    localparam logic [9:0] DATA_RESET = 10'h000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    // ********************************
    // Indirect access sequencer
    // ********************************
    typedef enum logic [1:0] {
        IDLE = 2'b01,
        ACCESS = 2'b10
    } indirect_state_type;
endpackage

// >>> design/rx_fifo_chain_config.sv
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module rx_fifo_chain_config
    import rx_chain_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic block_done,
    input wire logic frame_end,
    input wire logic [7:0] engine_channel,
    output logic dma_request,
    output logic [7:0] dma_channel,
    output logic [8:0] dma_channel_number
);
    // ********************************
    // Bus front end
    // ********************************
    logic write_pending;
    logic [11:0] write_addr;
    logic take;
    logic hit_start_select;
    logic hit_start_data;
    logic hit_next_select;
    logic hit_next_data;
    logic hit_hwm_select;
    logic hit_hwm_data;
    logic hit_tx_select;

    logic [7:0] start_id;
    logic start_dir;
    logic start_busy;
    logic start_rd;
    logic start_wr;
    logic [9:0] next_id;
    logic next_dir;
    logic next_busy;
    logic next_rd;
    logic next_wr;
    logic [7:0] hwm_id;
    logic hwm_dir;
    logic hwm_busy;
    logic hwm_rd;
    logic hwm_wr;
    logic [7:0] tx_id;
    logic tx_dir;
    logic tx_busy;
    logic [9:0] rx_start_data;
    logic [9:0] rx_next_data;
    logic [9:0] rx_hwm_data;
    logic [9:0] hwm_value;
    logic [9:0] current_block [CHANNELS];
    logic [9:0] next_block_ram [BLOCKS];
    logic [9:0] start_value;
    logic [9:0] next_value;
    logic [9:0] engine_block;
    logic dma_request_raw;
    logic [7:0] dma_channel_raw;

    function automatic logic [31:0] select_word(input logic [9:0] id,
                                                input logic dir,
                                                input logic busy);
        select_word = '0;
        select_word[9:0] = id;
        select_word[DIRECTION_BIT] = dir;
        select_word[BUSY_BIT] = busy;
    endfunction

    function automatic logic [31:0] data_word(input logic [9:0] value);
        data_word = {22'h00_0000, value};
    endfunction

    function automatic logic [8:0] channel_number(input logic [7:0] code);
        channel_number = {1'b0, code} + 9'h001;
    endfunction

    assign take = hsel && hready && htrans == HTRANS_NONSEQ;
    assign hit_start_select = write_pending
        && write_addr == RX_START_SELECT_ADDR;
    assign hit_start_data = write_pending && write_addr == RX_START_DATA_ADDR;
    assign hit_next_select = write_pending
        && write_addr == RX_NEXT_SELECT_ADDR;
    assign hit_next_data = write_pending && write_addr == RX_NEXT_DATA_ADDR;
    assign hit_hwm_select = write_pending && write_addr == RX_HWM_SELECT_ADDR;
    assign hit_hwm_data = write_pending && write_addr == RX_HWM_DATA_ADDR;
    assign hit_tx_select = write_pending && write_addr == TX_START_SELECT_ADDR;

    // Zero wait states, so hreadyout only leaves reset
    always_ff @(posedge clock) begin
        if (srst) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            write_pending <= 1'b0;
            write_addr <= '0;
        end else begin
            write_pending <= take && hwrite && haddr[31:12] == 20'h0_0000;
            write_addr <= haddr[11:0];
        end
    end

    // Read data is fetched at the address phase; unmapped reads zero
    always_ff @(posedge clock) begin
        if (srst) begin
            hrdata <= '0;
        end else if (take && !hwrite && haddr[31:12] == 20'h0_0000) begin
            case (haddr[11:0])
                RX_START_SELECT_ADDR: hrdata <= select_word({2'b00, start_id},
                    start_dir, start_busy);
                RX_START_DATA_ADDR: hrdata <= data_word(rx_start_data);
                RX_NEXT_SELECT_ADDR: hrdata <= select_word(next_id, next_dir,
                    next_busy);
                RX_NEXT_DATA_ADDR: hrdata <= data_word(rx_next_data);
                RX_HWM_SELECT_ADDR: hrdata <= select_word({2'b00, hwm_id},
                    hwm_dir, hwm_busy);
                RX_HWM_DATA_ADDR: hrdata <= data_word(rx_hwm_data);
                TX_START_SELECT_ADDR: hrdata <= select_word({2'b00, tx_id},
                    tx_dir, tx_busy);
                default: hrdata <= '0;
            endcase
        end else begin
            hrdata <= '0;
        end
    end

    // ********************************
    // Indirect access ports
    // ********************************
    indirect_access_ctrl #(.ID_WIDTH(CHANNEL_WIDTH)) u_start_ctrl (
        .clock(clock),
        .srst(srst),
        .select_write(hit_start_select),
        .write_data(hwdata[15:0]),
        .select_id(start_id),
        .indirect_direction(start_dir),
        .indirect_busy(start_busy),
        .access_read(start_rd),
        .access_write(start_wr)
    );
    indirect_access_ctrl #(.ID_WIDTH(BLOCK_WIDTH)) u_next_ctrl (
        .clock(clock),
        .srst(srst),
        .select_write(hit_next_select),
        .write_data(hwdata[15:0]),
        .select_id(next_id),
        .indirect_direction(next_dir),
        .indirect_busy(next_busy),
        .access_read(next_rd),
        .access_write(next_wr)
    );
    indirect_access_ctrl #(.ID_WIDTH(CHANNEL_WIDTH)) u_hwm_ctrl (
        .clock(clock),
        .srst(srst),
        .select_write(hit_hwm_select),
        .write_data(hwdata[15:0]),
        .select_id(hwm_id),
        .indirect_direction(hwm_dir),
        .indirect_busy(hwm_busy),
        .access_read(hwm_rd),
        .access_write(hwm_wr)
    );
    // Transmit RAMs live elsewhere; only the select handshake is here
    indirect_access_ctrl #(.ID_WIDTH(CHANNEL_WIDTH)) u_tx_ctrl (
        .clock(clock),
        .srst(srst),
        .select_write(hit_tx_select),
        .write_data(hwdata[15:0]),
        .select_id(tx_id),
        .indirect_direction(tx_dir),
        .indirect_busy(tx_busy),
        .access_read(),
        .access_write()
    );

    // ********************************
    // Data registers
    // ********************************
    // Host writes during busy are dropped to protect the read result
    always_ff @(posedge clock) begin
        if (srst) begin
            rx_start_data <= DATA_RESET;
        end else if (start_rd) begin
            rx_start_data <= start_value;
        end else if (hit_start_data && !start_busy) begin
            rx_start_data <= hwdata[BLOCK_WIDTH-1:0];
        end
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            rx_next_data <= DATA_RESET;
        end else if (next_rd) begin
            rx_next_data <= next_value;
        end else if (hit_next_data && !next_busy) begin
            rx_next_data <= hwdata[BLOCK_WIDTH-1:0];
        end
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            rx_hwm_data <= DATA_RESET;
        end else if (hwm_rd) begin
            rx_hwm_data <= hwm_value;
        end else if (hit_hwm_data && !hwm_busy) begin
            rx_hwm_data <= hwdata[BLOCK_WIDTH-1:0];
        end
    end

    // ********************************
    // Chain RAMs and write pointer
    // ********************************
    assign start_value = current_block[start_id];
    assign next_value = next_block_ram[next_id];
    assign engine_block = current_block[engine_channel];

    // Host programming wins over an engine advance on the same channel
    always_ff @(posedge clock) begin
        if (start_wr) begin
            current_block[start_id] <= rx_start_data;
        end
        if (block_done && !(start_wr && start_id == engine_channel)) begin
            current_block[engine_channel] <= next_block_ram[engine_block];
        end
    end

    always_ff @(posedge clock) begin
        if (next_wr) begin
            next_block_ram[next_id] <= rx_next_data;
        end
    end

    high_water_tracker u_tracker (
        .clock(clock),
        .srst(srst),
        .mark_write(hwm_wr),
        .mark_channel(hwm_id),
        .mark_data(rx_hwm_data),
        .mark_value(hwm_value),
        .block_done(block_done),
        .frame_end(frame_end),
        .engine_channel(engine_channel),
        .dma_request(dma_request_raw),
        .dma_channel(dma_channel_raw)
    );

    always_ff @(posedge clock) begin
        if (srst) begin
            dma_request <= 1'b0;
            dma_channel <= '0;
            dma_channel_number <= '0;
        end else begin
            dma_request <= dma_request_raw;
            dma_channel <= dma_channel_raw;
            dma_channel_number <= channel_number(dma_channel_raw);
        end
    end

    // ********************************
    // Checks
    // ********************************
    property p_start_read;
        @(posedge clock) disable iff (srst)
        start_rd |=> rx_start_data == $past(start_value) && !start_busy;
    endproperty
    a_start_read: assert property (p_start_read)
        else $error("start read did not return live pointer");
    property p_start_write;
        @(posedge clock) disable iff (srst)
        (start_wr && !block_done) |=> start_value == $past(rx_start_data);
    endproperty
    a_start_write: assert property (p_start_write)
        else $error("start pointer write lost");
    property p_next_cycle;
        @(posedge clock) disable iff (srst)
        next_wr |=> next_value == $past(rx_next_data) ##1 !next_busy;
    endproperty
    a_next_cycle: assert property (p_next_cycle)
        else $error("next pointer write lost");
    property p_next_read;
        @(posedge clock) disable iff (srst)
        next_rd |=> rx_next_data == $past(next_value);
    endproperty
    a_next_read: assert property (p_next_read)
        else $error("next pointer read wrong");
    property p_hwm_round;
        @(posedge clock) disable iff (srst)
        hwm_wr |=> hwm_value == $past(rx_hwm_data);
    endproperty
    a_hwm_round: assert property (p_hwm_round)
        else $error("high water write lost");
    property p_block_id;
        @(posedge clock) disable iff (srst)
        (hit_next_select && !next_busy) |=> next_id == $past(hwdata[9:0]);
    endproperty
    a_block_id: assert property (p_block_id)
        else $error("block select not ten bits");
    property p_reset_select;
        @(posedge clock) srst |=> start_id == 8'h00 && !start_busy
            && next_id == 10'h000 && !hwm_busy && tx_id == 8'h00;
    endproperty
    a_reset_select: assert property (p_reset_select)
        else $error("select registers not cleared");
    property p_reserved_zero;
        @(posedge clock) disable iff (srst)
        hrdata[31:16] == 16'h0000 && hrdata[13:10] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");
    property p_number;
        @(posedge clock) disable iff (srst)
        dma_request_raw |=> dma_request
            && dma_channel_number == {1'b0, dma_channel} + 9'h001;
    endproperty
    a_number: assert property (p_number)
        else $error("channel number not code plus one");
    c_start_read: cover property (@(posedge clock) disable iff (srst)
        start_rd ##1 !start_busy);
    c_next_write: cover property (@(posedge clock) disable iff (srst)
        next_wr);
    c_request: cover property (@(posedge clock) disable iff (srst)
        dma_request);
endmodule
`default_nettype wire

// >>> test/test_rx_fifo_chain_config.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module test_rx_fifo_chain_config
    import rx_chain_pkg::*;
;
    // ****************************************
    // Clock, bus and engine signals
    // ****************************************
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic block_done = 1'b0;
    logic frame_end = 1'b0;
    logic [7:0] engine_channel = 8'h00;
    logic dma_request;
    logic [7:0] dma_channel;
    logic [8:0] dma_channel_number;
    int n_errors = 0;
    int check_count = 0;
    int dma_count = 0;
    logic [7:0] dma_last_ch = 8'h00;
    logic [8:0] dma_last_num = 9'h000;
    logic [31:0] rd;
    logic [9:0] chain [4] = '{10'h004, 10'h007, 10'h009, 10'h00c};

    always #25 clock = ~clock;

    rx_fifo_chain_config dut (
        .clock(clock),
        .srst(srst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .block_done(block_done),
        .frame_end(frame_end),
        .engine_channel(engine_channel),
        .dma_request(dma_request),
        .dma_channel(dma_channel),
        .dma_channel_number(dma_channel_number)
    );

    // One-cycle pulse, so every edge is inspected
    always @(posedge clock) begin
        if (dma_request === 1'b1) begin
            dma_count++;
            dma_last_ch = dma_channel;
            dma_last_num = dma_channel_number;
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic close_out();
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            n_errors++;
            close_out();
        end
    endtask

    // Entered right after an edge, so transfers run back to back
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wr ? wd : 32'h0000_0000;
        wait_ready();
        q = hrdata;
        `CHK(hresp, 1'b0)
    endtask

    task automatic wr_reg(input logic [31:0] a, input logic [31:0] wd);
        logic [31:0] q;
        bus(1'b1, a, wd, q);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        `CHK(q, exp)
    endtask

    // Command, check busy at once, then poll it down
    task automatic cmd(input logic [31:0] a, input logic [15:0] v);
        logic [31:0] q;
        int n;
        wr_reg(a, {16'h0000, v});
        bus(1'b0, a, 32'h0000_0000, q);
        `CHK(q[BUSY_BIT], 1'b1)
        n = 0;
        do begin
            bus(1'b0, a, 32'h0000_0000, q);
            n++;
        end while (q[BUSY_BIT] !== 1'b0 && n < 20);
        `CHK(q[BUSY_BIT], 1'b0)
        if (q[BUSY_BIT] !== 1'b0) begin
            close_out();
        end
    endtask

    task automatic engine(input logic d, input logic f,
                          input logic [7:0] ch);
        block_done <= d;
        frame_end <= f;
        engine_channel <= ch;
        @(posedge clock);
        block_done <= 1'b0;
        frame_end <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        wait_ready();
        rd_chk(32'h0000_0900, 32'h0000_0000);
        rd_chk(32'h0000_0910, 32'h0000_0000);
        rd_chk(32'h0000_0920, 32'h0000_0000);
        rd_chk(32'h0000_0980, 32'h0000_0000);
        // Circular chain 4 -> 7 -> 9 -> 12 -> 4
        for (int i = 0; i < 4; i++) begin
            wr_reg(32'h0000_0914, {22'h0, chain[(i + 1) % 4]});
            cmd(32'h0000_0910, {6'h00, chain[i]});
        end
        wr_reg(32'h0000_0914, 32'h0000_0155);
        cmd(32'h0000_0910, 16'h03ff);
        wr_reg(32'h0000_0914, 32'h0000_0000);
        cmd(32'h0000_0910, 16'h43ff);
        rd_chk(32'h0000_0914, 32'h0000_0155);
        rd_chk(32'h0000_0910, 32'h0000_43ff);
        rd_chk(32'h0000_0914, 32'h0000_0155);
        wr_reg(32'h0000_0924, 32'h0000_0003);
        cmd(32'h0000_0920, 16'h0005);
        wr_reg(32'h0000_0924, 32'hffff_ffff);
        rd_chk(32'h0000_0924, 32'h0000_03ff);
        cmd(32'h0000_0920, 16'hff05);
        rd_chk(32'h0000_0920, 32'h0000_4005);
        rd_chk(32'h0000_0924, 32'h0000_0003);
        wr_reg(32'h0000_0904, 32'h0000_0004);
        cmd(32'h0000_0900, 16'h0005);
        wr_reg(32'h0000_0904, 32'h0000_03ff);
        cmd(32'h0000_0900, 16'h4005);
        rd_chk(32'h0000_0904, 32'h0000_0004);
        engine(1'b1, 1'b0, 8'h05);
        cmd(32'h0000_0900, 16'h4005);
        rd_chk(32'h0000_0904, 32'h0000_0007);
        engine(1'b1, 1'b0, 8'h05);
        `CHK(dma_count, 0)
        engine(1'b1, 1'b0, 8'h05);
        `CHK(dma_count, 1)
        `CHK(dma_last_ch, 8'h05)
        `CHK(dma_last_num, 9'h006)
        cmd(32'h0000_0900, 16'h4005);
        rd_chk(32'h0000_0904, 32'h0000_000c);
        engine(1'b0, 1'b1, 8'hff);
        `CHK(dma_count, 2)
        `CHK(dma_last_ch, 8'hff)
        `CHK(dma_last_num, 9'h100)
        engine(1'b0, 1'b1, 8'h00);
        `CHK(dma_last_num, 9'h001)
        cmd(32'h0000_0980, 16'h4012);
        rd_chk(32'h0000_0980, 32'h0000_4012);
        // Unmapped place: writes vanish, reads give zero
        wr_reg(32'h0000_09f0, 32'h0000_abcd);
        rd_chk(32'h0000_09f0, 32'h0000_0000);
        close_out();
    end
endmodule
`default_nettype wire
